// ### logic/pfs_pkg.sv
// Package of constants and carrier types for the protection switch sequencer
package pfs_pkg;

  // ==========================================================
  // Clock and timing figures
  // ==========================================================
  // Reference clock rate in kHz
  localparam int unsigned CLK_KHZ = 40000;
  // Overvoltage debounce, in microseconds
  localparam int unsigned OVERVOLTAGE_DEBOUNCE_TIME_US = 512;
  // Reverse block delay, in nanoseconds
  localparam int unsigned REVERSE_BLOCK_DELAY_TIME_NS = 500;
  // Inrush clamp window, in microseconds
  localparam int unsigned INRUSH_WINDOW_US = 380;
  // Restart blanking, in milliseconds
  localparam int unsigned RESTART_BLANKING_TIME_MS = 64;
  // Turn-on delay, in milliseconds
  localparam int unsigned TURN_ON_DELAY_MS = 8;
  // Current limit ramp length, in microseconds
  localparam int unsigned ILIM_RAMP_US = 1250;

  // Derived cycle counts (longest figures round down, least round up)
  localparam int unsigned OV_DEB_CYC = OVERVOLTAGE_DEBOUNCE_TIME_US * CLK_KHZ
                                       / 1000;
  localparam int unsigned REV_DEL_CYC =
    (REVERSE_BLOCK_DELAY_TIME_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int unsigned INRUSH_CYC = INRUSH_WINDOW_US * CLK_KHZ / 1000;
  localparam int unsigned BLANK_CYC = RESTART_BLANKING_TIME_MS * CLK_KHZ;
  localparam int unsigned TON_DLY_CYC = TURN_ON_DELAY_MS * CLK_KHZ;
  localparam int unsigned ILIM_RAMP_CYC = ILIM_RAMP_US * CLK_KHZ / 1000;

  // ==========================================================
  // Register map (word aligned byte offsets)
  // ==========================================================
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] SS_OFS = 4'h8;
  // Control reset value: software enable bit clear
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // Default soft-start length in cycles, 2 ms at 40 MHz
  localparam logic [31:0] SS_RST = 32'h0001_3880;
  // Control bit positions
  localparam int unsigned CTRL_SW_EN_BIT = 0;
  localparam int unsigned CTRL_USE_SW_BIT = 1;

  // ==========================================================
  // Sequencer states
  // ==========================================================
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_CHECK = 3'b001,
    ST_DELAY = 3'b010,
    ST_RAMP = 3'b011,
    ST_ON = 3'b100,
    ST_REVERSE = 3'b101,
    ST_BLANK = 3'b110,
    ST_LATCH = 3'b111
  } pfs_state_t;

  // ==========================================================
  // Carrier of analog comparator results
  // ==========================================================
  typedef struct packed {
    logic enable;                  // Enable pin level
    logic above_on_threshold;      // Input rail above 3.35 V
    logic below_lockout;           // Input rail below 3 V
    logic input_overvoltage_trip;  // Input rail above overvoltage level
    logic thermal_trip;            // Die at 140 C
    logic drop_below_target;       // In-to-out drop under 35 mV
    logic reverse_trip;            // Output 50 mV above input
    logic inrush_clamped;          // Current held by limit ramp
  } pfs_sense_t;

  // Gate drive outputs
  typedef struct packed {
    logic switch_on;    // Power switch gate enable
    logic ramp_active;  // Soft-start slope running
    logic ilim_active;  // Startup current limit armed
  } pfs_drive_t;

endpackage

// ### logic/pfs_sequencer.sv
// Control and fault sequencer of a high-side protection switch
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
// ==========================================================
// Notes on behaviour
// - Enabled only with enable high, no lockout.
// - Leave lockout above 3.35 V, enter below 3 V.
// - Watch overvoltage continuously while enabled.
// - Overvoltage while on: off after debounce.
// - Overvoltage while off blocks turn-on.
// - Overvoltage always asserts the fault flag; code flags it only on latch, at check or after debounce.
// - Switch off at 140 C die temperature.
// - Latch off until enable toggle or power cycle.
// - Off when drop falls under 35 mV.
// - Reverse comparator turns off after delay.
// - Hold off while output above input.
// - Check faults, then on after delay.
// - Ramp output linearly to the input.
// - Current limit ramps up within 1.25 ms.
// - Shut down after 380 us clamp.
// - Clear clamp timer when clamp ends.
// - Restart after 64 ms blanking.
// - After soft-start, limit and shutdown disabled.
// - Flag asserted for overvoltage, thermal; not reverse.
// - Reverse turn-off restarts without soft-start.
// - Turn-on delay typically 8 ms.
// ==========================================================
module pfs_sequencer #(
  parameter int unsigned OV_DEB = pfs_pkg::OV_DEB_CYC,
  parameter int unsigned REV_DEL = pfs_pkg::REV_DEL_CYC,
  parameter int unsigned INRUSH = pfs_pkg::INRUSH_CYC,
  parameter int unsigned BLANK = pfs_pkg::BLANK_CYC,
  parameter int unsigned TON_DLY = pfs_pkg::TON_DLY_CYC,
  parameter int unsigned ILIM_RAMP = pfs_pkg::ILIM_RAMP_CYC,
  parameter int unsigned CW = 32
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Analog comparator results, asynchronous
  input wire pfs_pkg::pfs_sense_t sense_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Switch drive and fault flag (open drain)
  output pfs_pkg::pfs_drive_t drive_o,
  output logic [CW-1:0] ilim_level_o,
  output logic fault_flag_n_o,
  output logic fault_flag_n_oe_o
);
  import pfs_pkg::*;
  // ==========================================================
  // Elaboration checks
  // ==========================================================
  // Every count must fit the counter and be at least one cycle
  if (CW < 24 || CW > 32) begin : g_cw_bad
    $error("counter width out of range");
  end
  if (OV_DEB < 1 || REV_DEL < 1 || INRUSH < 1 || BLANK < 1 ||
      TON_DLY < 1 || ILIM_RAMP < 1) begin : g_cnt_bad
    $error("timer counts must be at least one");
  end
  // ==========================================================
  // Input synchronisers, three stages
  // ==========================================================
  localparam int unsigned SW = $bits(pfs_sense_t);
  logic [SW-1:0] sync1; // First stage, read only by stage two
  logic [SW-1:0] sync2; // Second stage
  logic [SW-1:0] sync3; // Third stage
  logic [SW-1:0] filt;  // Accepted levels
  logic [SW-1:0] next_filt;
  pfs_sense_t s;        // Accepted levels as struct
  // Accept a change once stages two and three agree
  always_comb begin
    next_filt = filt;
    for (int i = 0; i < SW; i++) begin
      if (sync2[i] == sync3[i]) begin
        next_filt[i] = sync2[i];
      end
    end
  end

  // Register synchroniser stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt <= '0;
    end else if (ce_i) begin
      sync1 <= sense_i;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
    end
  end
  assign s = pfs_sense_t'(filt);
  // ==========================================================
  // Wishbone register file
  // ==========================================================
  logic [31:0] ctrl;      // Software enable override
  logic [31:0] ss_len;    // Soft-start length in cycles
  logic [31:0] next_ctrl;
  logic [31:0] next_ss_len;
  logic next_ack;
  logic [31:0] next_rdat;
  logic [31:0] status_word;
  logic req;
  // Byte-lane merge used by both writable registers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction
  // Single-cycle answer; ack drops the cycle after it rises
  always_comb begin
    req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_ack = req;
    next_ctrl = ctrl;
    next_ss_len = ss_len;
    next_rdat = wb_dat_o;
    if (req) begin
      case (wb_adr_i)
        CTRL_OFS: begin
          if (wb_we_i) begin
            next_ctrl = merge(ctrl, wb_dat_i, wb_sel_i) & 32'h0000_0003;
          end
          next_rdat = ctrl;
        end
        STATUS_OFS: begin
          next_rdat = status_word;
        end
        SS_OFS: begin
          if (wb_we_i) begin
            next_ss_len = merge(ss_len, wb_dat_i, wb_sel_i);
          end
          next_rdat = ss_len;
        end
        // Unmapped: acked, reads zero, writes dropped
        default: begin
          next_rdat = 32'h0000_0000;
        end
      endcase
    end
  end

  // Register bus state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RST;
      ss_len <= SS_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ctrl <= next_ctrl;
      ss_len <= next_ss_len;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_rdat;
    end
  end

  // ==========================================================
  // Sequencer
  // ==========================================================
  pfs_state_t state;
  pfs_state_t next_state;
  logic [CW-1:0] cnt;       // Shared state timer
  logic [CW-1:0] next_cnt;
  logic [CW-1:0] ov_cnt;    // Overvoltage debounce timer
  logic [CW-1:0] next_ov_cnt;
  logic [CW-1:0] clamp_cnt; // Inrush clamp window timer
  logic [CW-1:0] next_clamp_cnt;
  logic [CW-1:0] rev_cnt;   // Reverse delay timer
  logic [CW-1:0] next_rev_cnt;
  logic unlocked;           // Lockout released, hysteretic
  logic next_unlocked;
  logic en_q;               // Previous enabled level
  logic fault_low;          // Flag pulled low
  logic next_fault_low;
  logic enabled;
  logic rise;
  // Saturating increment shared by all timers
  // one clock, parameter lengths
  function automatic logic [CW-1:0] inc(input logic [CW-1:0] v);
    return (&v) ? v : v + 1'b1;
  endfunction
  // software may hold off, never enable past a low pin
  logic en_src;
  assign en_src = s.enable && (!ctrl[CTRL_USE_SW_BIT] ||
                               ctrl[CTRL_SW_EN_BIT]);
  // Next-state logic of the sequencer and its timers
  always_comb begin
    next_unlocked = unlocked;
    if (s.below_lockout) begin
      next_unlocked = 1'b0;
    end else if (s.above_on_threshold) begin
      next_unlocked = 1'b1;
    end
    // enabled needs enable and no lockout
    enabled = en_src && unlocked;
    rise = enabled && !en_q;
    next_state = state;
    next_cnt = inc(cnt);
    next_rev_cnt = s.reverse_trip ? inc(rev_cnt) : '0;
    next_fault_low = fault_low;
    next_ov_cnt = (enabled && s.input_overvoltage_trip) ? inc(ov_cnt) : '0;
    // clamp timer clears when clamp ends
    next_clamp_cnt = (state == ST_RAMP && s.inrush_clamped) ?
                     inc(clamp_cnt) : '0;
    if (!enabled) begin
      // enable toggle or supply cycle clears latch
      next_state = ST_OFF;
      next_fault_low = 1'b0;
      next_cnt = '0;
    end else begin
      case (state)
        ST_OFF: begin
          if (rise) begin
            next_state = ST_CHECK;
            next_cnt = '0;
          end
        end
        ST_CHECK: begin
          next_cnt = '0;
          if (s.input_overvoltage_trip || s.thermal_trip) begin
            next_state = ST_LATCH;
            next_fault_low = 1'b1;
          // hold off while output above input
          end else if (!s.reverse_trip) begin
            next_state = ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (cnt >= CW'(TON_DLY - 1)) begin
            next_state = ST_RAMP;
            next_cnt = '0;
          end
        end
        // linear ramp for the soft-start length
        ST_RAMP: begin
          // shut down after the clamp window
          if (clamp_cnt >= CW'(INRUSH - 1)) begin
            next_state = ST_BLANK;
            next_fault_low = 1'b1;
            next_cnt = '0;
          // soft-start over, limit and shutdown off
          end else if (cnt >= ss_len[CW-1:0]) begin
            next_state = ST_ON;
            next_cnt = '0;
          end
        end
        ST_ON: begin
          if (s.drop_below_target ||
              rev_cnt >= CW'(REV_DEL)) begin
            next_state = ST_REVERSE;
          end
        end
        ST_REVERSE: begin
          if (!s.reverse_trip && !s.drop_below_target) begin
            next_state = ST_ON;
          end
        end
        ST_BLANK: begin
          if (cnt >= CW'(BLANK - 1)) begin
            next_state = ST_CHECK;
            next_fault_low = 1'b0;
            next_cnt = '0;
          end
        end
        ST_LATCH: begin
          next_cnt = '0;
        end
        default: begin
          next_state = ST_OFF;
        end
      endcase
      // debounced overvoltage or thermal trip turns off and latches
      if ((state != ST_LATCH) && (ov_cnt >= CW'(OV_DEB - 1) ||
          s.thermal_trip)) begin
        next_state = ST_LATCH;
        next_fault_low = 1'b1;
      end
    end
  end
  // Register sequencer state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_OFF;
      cnt <= '0;
      ov_cnt <= '0;
      clamp_cnt <= '0;
      rev_cnt <= '0;
      unlocked <= 1'b0;
      en_q <= 1'b0;
      fault_low <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      cnt <= next_cnt;
      ov_cnt <= next_ov_cnt;
      clamp_cnt <= next_clamp_cnt;
      rev_cnt <= next_rev_cnt;
      unlocked <= next_unlocked;
      en_q <= enabled;
      fault_low <= next_fault_low;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // limit rises linearly over the ramp length
  logic [CW-1:0] ilim_next;
  always_comb begin
    ilim_next = '0;
    if (state == ST_RAMP) begin
      ilim_next = (cnt >= CW'(ILIM_RAMP)) ? CW'(ILIM_RAMP) : cnt;
    end
  end
  // Drive registers, data outputs from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_o <= '0;
      ilim_level_o <= '0;
    end else if (ce_i) begin
      drive_o.switch_on <= (next_state == ST_RAMP) || (next_state == ST_ON);
      drive_o.ramp_active <= (next_state == ST_RAMP);
      drive_o.ilim_active <= (next_state == ST_RAMP);
      ilim_level_o <= ilim_next;
    end
  end

  // Open drain flag: drive low only while a fault is held
  assign fault_flag_n_o = 1'b0;
  assign fault_flag_n_oe_o = fault_low;

  // Status word: state, flag, lockout, live comparators
  assign status_word = {16'h0000, filt, 3'b000, unlocked, fault_low,
                        state};
endmodule

// ### verification/pfs_checker_assertions.sv
// Checker of the sequencer's pin behaviour
`timescale 1ns/1ps
module pfs_checker #(
  parameter int unsigned OV_DEB = 8,
  parameter int unsigned INRUSH = 8,
  parameter int unsigned CW = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched pins
  input wire pfs_pkg::pfs_sense_t sense_i,
  input wire pfs_pkg::pfs_drive_t drive_o,
  input wire logic [CW-1:0] ilim_level_o,
  input wire logic fault_flag_n_oe_o
);
  import pfs_pkg::*;
  // ==========================================================
  // Run-length counters
  // ==========================================================
  logic live;  // Enabled and unlocked
  logic [7:0] ov_cnt;  // Overvoltage while live
  logic [7:0] ir_cnt;  // Clamped while ramping
  logic [7:0] next_ov_cnt;
  logic [7:0] next_ir_cnt;
  assign live = sense_i.enable & sense_i.above_on_threshold
                & ~sense_i.below_lockout;
  // Saturate so a long fault never wraps back to zero
  always_comb begin
    next_ov_cnt = 8'h00;
    next_ir_cnt = 8'h00;
    if (sense_i.input_overvoltage_trip && live) begin
      next_ov_cnt = ov_cnt + {7'h00, ov_cnt != 8'hFF};
    end
    if (sense_i.inrush_clamped && drive_o.ramp_active) begin
      next_ir_cnt = ir_cnt + {7'h00, ir_cnt != 8'hFF};
    end
  end
  // Registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ov_cnt <= 8'h00;
      ir_cnt <= 8'h00;
    end else begin
      ov_cnt <= next_ov_cnt;
      ir_cnt <= next_ir_cnt;
    end
  end
  // ==========================================================
  // Properties
  // ==========================================================
  // Margins cover the sense synchroniser and the output register
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_off; !sense_i.enable [*8]; endsequence
  sequence s_low; sense_i.below_lockout [*8]; endsequence
  sequence s_hot; (sense_i.thermal_trip && live) [*8]; endsequence
  a_ramp_on_switch: assert property (
    drive_o.ramp_active |-> drive_o.switch_on)
    else $error("ramp without switch");
  a_ilim_idle: assert property (
    !drive_o.ramp_active [*2] |-> ilim_level_o == '0)
    else $error("limit level outside ramp");
  a_disable_off: assert property (
    s_off |-> ##2 (drive_o == 3'b000 && !fault_flag_n_oe_o))
    else $error("still active while disabled");
  a_lockout_off: assert property (
    s_low |-> ##2 !drive_o.switch_on)
    else $error("switch on in lockout");
  a_thermal_latch: assert property (
    s_hot |-> ##2 (!drive_o.switch_on && fault_flag_n_oe_o))
    else $error("no thermal shutdown");
  a_ov_debounce: assert property (
    $past(drive_o.switch_on) && ov_cnt != 0 && ov_cnt <= OV_DEB
    |-> drive_o.switch_on)
    else $error("overvoltage cut before debounce");
  a_ov_latch: assert property (
    ov_cnt >= OV_DEB + 8 |-> !drive_o.switch_on && fault_flag_n_oe_o)
    else $error("overvoltage not latched");
  a_inrush_window: assert property (
    ir_cnt <= INRUSH + 8)
    else $error("clamp held past window");
endmodule

bind pfs_sequencer pfs_checker #(
  .OV_DEB(OV_DEB), .INRUSH(INRUSH), .CW(CW)
) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .sense_i(sense_i), .drive_o(drive_o),
  .ilim_level_o(ilim_level_o), .fault_flag_n_oe_o(fault_flag_n_oe_o)
);

// ### verification/pfs_ctrl_model.sv
// Model of the system controller at the enable and flag pins
`timescale 1ns/1ps
module pfs_ctrl_model (
  // Clock and the bench's enable request
  input wire logic clk_i,
  input wire logic en_req_i,
  // Open-drain flag as the sequencer drives it
  input wire logic flag_n_i,
  input wire logic flag_n_oe_i,
  // Levels seen on the board
  output logic enable_o,
  output logic flag_pin_o
);
  // clean enable levels
  // Only a firm 0 or 1, moved just after an edge
  always @(posedge clk_i) begin
    enable_o <= en_req_i;
  end
  // Board pull-up holds the flag high when released
  assign flag_pin_o = flag_n_oe_i ? flag_n_i : 1'b1;
endmodule

// ### verification/tb_protection_switch_fault_sequencer.sv
// Self-checking bench of the protection switch sequencer
`timescale 1ns/1ps
module tb_protection_switch_fault_sequencer;
  import pfs_pkg::*;
  // Short timers keep the run brief
  localparam int TON = 16;
  localparam int BLK = 16;
  localparam int OVD = 8;
  localparam int ILR = 16;
  localparam int SW = 0;
  localparam int RMP = 1;
  localparam int FLG = 2;
  // ==========================================================
  // Pins, bus and counters
  // ==========================================================
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic en_req = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'hF;  // Byte lanes of the next bus call
  logic ce = 1'b1;  // Clock enable, low freezes the block
  logic [31:0] rdat;
  logic [31:0] q;
  logic [31:0] ilim;  // Current limit level
  logic ack, en_w, flag_w, oe_w, flag_pin;
  pfs_sense_t sn = '0;  // Analog levels from the bench
  pfs_sense_t sense_w;  // Same, enable from the controller
  pfs_drive_t drv;
  int err_total = 0;
  int n_compared = 0;
  int n;  // Cycles spent in the last wait
  always #12.5 clk_i = ~clk_i;
  always_comb begin
    sense_w = sn;
    sense_w.enable = en_w;
  end
  pfs_sequencer #(
    .OV_DEB(OVD), .REV_DEL(2), .INRUSH(8), .BLANK(BLK),
    .TON_DLY(TON), .ILIM_RAMP(ILR), .CW(32)
  ) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .sense_i(sense_w),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .drive_o(drv), .ilim_level_o(ilim), .fault_flag_n_o(flag_w),
    .fault_flag_n_oe_o(oe_w)
  );
  pfs_ctrl_model i_ctrl (
    .clk_i(clk_i), .en_req_i(en_req), .flag_n_i(flag_w),
    .flag_n_oe_i(oe_w), .enable_o(en_w), .flag_pin_o(flag_pin)
  );
  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk_w(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_b(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Classic cycle: hold until ack is sampled high, then release
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = rdat;
    cyc <= 1'b0;
    chk_b("bus ack", 1'b1, ack);
  endtask
  function automatic logic pick(input int s);
    case (s)
      SW: pick = drv.switch_on;
      RMP: pick = drv.ramp_active;
      default: pick = flag_pin;
    endcase
  endfunction
  // Bounded wait; running out ends the run
  task automatic wait_for(input int s, input logic v);
    n = 0;
    while (pick(s) !== v) begin
      @(posedge clk_i);
      n++;
      if (n > 3000) begin
        chk_b("wait", v, pick(s));
        stop_test();
      end
    end
  endtask
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CTRL_OFS, 32'h0);
    chk_w("ctrl", CTRL_RST, q);
    wb(1'b0, SS_OFS, 32'h0);
    chk_w("ss_len", SS_RST, q);
    wb(1'b1, 4'hC, 32'hFFFF_FFFF);
    wb(1'b0, 4'hC, 32'h0);
    chk_w("unmapped", 32'h0, q);
    wb(1'b1, SS_OFS, 32'h0000_0028);
    // Only byte lane zero may land
    sel <= 4'h1;
    wb(1'b1, SS_OFS, 32'hFFFF_FF28);
    sel <= 4'hF;
    wb(1'b0, SS_OFS, 32'h0);
    chk_w("ss_len", 32'h0000_0028, q);
    $display("test registers done");
    // Plain start, short clamp pulses in the ramp
    sn.above_on_threshold <= 1'b1;
    en_req <= 1'b1;
    wait_for(SW, 1'b1);
    chk_b("delay", 1'b1, n > TON);
    chk_w("drive", 32'h7, {29'h0, drv});
    chk_w("ilim start", 32'h0, ilim);
    repeat (2) begin
      sn.inrush_clamped <= 1'b1;
      repeat (6) @(posedge clk_i);
      sn.inrush_clamped <= 1'b0;
      repeat (6) @(posedge clk_i);
    end
    chk_w("clamp reset", 32'h7, {29'h0, drv});
    chk_w("ilim top", ILR, ilim);
    wait_for(RMP, 1'b0);
    chk_w("drive", 32'h4, {29'h0, drv});
    $display("test start done");
    // Lost drop and reverse current recover without a ramp
    for (int k = 1; k <= 2; k++) begin
      sn[k] <= 1'b1;
      wait_for(SW, 1'b0);
      chk_b("flag", 1'b1, flag_pin);
      sn[k] <= 1'b0;
      wait_for(SW, 1'b1);
      chk_w("drive", 32'h4, {29'h0, drv});
    end
    // Frozen clock enable must not see a drop pulse
    ce <= 1'b0;
    sn.drop_below_target <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk_w("frozen", 32'h4, {29'h0, drv});
    sn.drop_below_target <= 1'b0;
    repeat (8) @(posedge clk_i);
    ce <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk_w("thawed", 32'h4, {29'h0, drv});
    $display("test reverse done");
    // Overvoltage while on latches after debounce
    sn.input_overvoltage_trip <= 1'b1;
    wait_for(SW, 1'b0);
    chk_b("debounce", 1'b1, n >= OVD);
    wait_for(FLG, 1'b0);
    sn.input_overvoltage_trip <= 1'b0;
    repeat (40) @(posedge clk_i);
    chk_b("latched", 1'b0, drv.switch_on);
    chk_b("flag", 1'b0, flag_pin);
    en_req <= 1'b0;
    wait_for(FLG, 1'b1);
    // Overvoltage before turn-on blocks it
    sn.input_overvoltage_trip <= 1'b1;
    en_req <= 1'b1;
    wait_for(FLG, 1'b0);
    repeat (40) @(posedge clk_i);
    chk_b("blocked", 1'b0, drv.switch_on);
    en_req <= 1'b0;
    sn.input_overvoltage_trip <= 1'b0;
    wait_for(FLG, 1'b1);
    $display("test overvoltage done");
    // Thermal trip latches off
    en_req <= 1'b1;
    wait_for(SW, 1'b1);
    sn.thermal_trip <= 1'b1;
    wait_for(SW, 1'b0);
    wait_for(FLG, 1'b0);
    chk_b("hot flag", 1'b1, n < 4);
    en_req <= 1'b0;
    sn.thermal_trip <= 1'b0;
    wait_for(FLG, 1'b1);
    // Startup short: shutdown, blanking, restart
    en_req <= 1'b1;
    wait_for(SW, 1'b1);
    sn.inrush_clamped <= 1'b1;
    wait_for(SW, 1'b0);
    chk_b("clamp time", 1'b1, n >= 8);
    wait_for(FLG, 1'b0);
    sn.inrush_clamped <= 1'b0;
    wait_for(FLG, 1'b1);
    chk_b("blanking", 1'b1, n >= BLK - 2);
    wait_for(SW, 1'b1);
    chk_w("drive", 32'h7, {29'h0, drv});
    wait_for(RMP, 1'b0);
    $display("test faults done");
    // Lockout with hysteresis, reverse hold at start
    sn.below_lockout <= 1'b1;
    sn.above_on_threshold <= 1'b0;
    wait_for(SW, 1'b0);
    chk_b("flag", 1'b1, flag_pin);
    sn.below_lockout <= 1'b0;
    repeat (40) @(posedge clk_i);
    chk_b("locked", 1'b0, drv.switch_on);
    sn.reverse_trip <= 1'b1;
    sn.above_on_threshold <= 1'b1;
    repeat (40) @(posedge clk_i);
    chk_b("reverse hold", 1'b0, drv.switch_on);
    sn.reverse_trip <= 1'b0;
    wait_for(SW, 1'b1);
    // Software hold keeps the switch off with the pin high
    wb(1'b1, CTRL_OFS, 32'h0000_0002);
    wait_for(SW, 1'b0);
    wb(1'b0, STATUS_OFS, 32'h0);
    chk_w("status", 32'h0000_C010, q);
    wb(1'b1, CTRL_OFS, 32'h0000_0003);
    wait_for(SW, 1'b1);
    $display("test lockout done");
    stop_test();
  end
endmodule
